// >>> logic/adc_conversion_control.sv
// Successive-approximation converter control with an AHB-Lite register slave
// Overview of operation
// - Ten-bit result found by successive approximation, held in a ten-bit register.
// - Four-bit channel field in control 0 bits 5:2 picks the sampled channel.
// - Reference bit 6 set uses the external reference pin, clear uses supply.
// - A full conversion lasts exactly eleven bit periods.
// - Clock select 000/100/001/101/010/110 gives 2/4/8/16/32/64 clocks; x11 the RC clock.
// - Writing one to the go flag starts a conversion on the selected channel.
// - On completion go clears, done flag sets, interrupt raised when enabled.
// - Clearing go mid-conversion aborts it and keeps the previous result.
// - After abort wait two bit periods, then acquisition restarts automatically.
// - Justify bit 7 selects left or right placement over two result registers.
// - Twelve pin select bits over two registers: one analog, zero digital.
// - Analog pins lose digital input; port reads zero.
// - Justify bit one means right justified, zero means left justified.
// - Channel codes 0000 to 1011 select external channels 0 to 11.
// - Power bit set enables the converter; clear shuts it off.
`timescale 1ns/100ps
`default_nettype none

module adc_conversion_control
	import adc_ctrl_pkg::*;
#(
	parameter int unsigned RC_DIV = RC_DIV_DFLT
)
(
	input  wire logic        I_MCLK,
	input  wire logic        I_RESETN,
	input  wire logic        I_HSEL,
	input  wire logic [11:0] I_HADDR,
	input  wire logic [1:0]  I_HTRANS,
	input  wire logic        I_HWRITE,
	input  wire logic [2:0]  I_HSIZE,
	input  wire logic [31:0] I_HWDATA,
	input  wire logic        I_HREADY,
	output logic             O_HREADYOUT,
	output logic [31:0]      O_HRDATA,
	output logic             O_HRESP,
	input  wire logic        I_CMP_HIGH,
	output logic [3:0]       O_CHANNEL,
	output logic             O_REF_EXT,
	output logic             O_CONV_POWER,
	output logic             O_SAMPLE,
	output logic [9:0]       O_DAC_CODE,
	output logic             O_CONV_IRQ,
	input  wire logic [11:0] I_PIN,
	output logic [11:0]      O_PORT_READ,
	output logic [11:0]      O_DIGITAL_IN_EN
);

	if (RC_DIV < 2 || RC_DIV > 255)
	begin : g_chk
		$error("RC_DIV must lie in 2..255");
	end

	state_t      state;
	state_t      next_state;
	logic        justify;
	logic        ref_ext;
	logic [3:0]  channel;
	logic        go;
	logic        power;
	logic [2:0]  clk_sel;
	logic        done_flag;
	logic        done_en;
	logic [7:0]  sel_lo;
	logic [3:0]  sel_hi;
	logic [9:0]  result;
	logic [9:0]  sar;
	logic [3:0]  tad_idx;
	logic [7:0]  div_cnt;
	logic [7:0]  conv_div;
	logic        cmp_s1;
	logic        cmp_s2;
	logic [11:0] pin_s1;
	logic [11:0] pin_s2;
	logic        wr_pend;
	logic [7:0]  wr_idx;
	logic        irq;
	logic        sample;
	logic [11:0] port_read;
	logic [11:0] din_en;
	logic [31:0] hrdata;
	logic        hready;
	logic [7:0]  rd_byte;
	logic [15:0] conv_cyc;
	logic [15:0] abort_cyc;

	// Bit period in system clocks for a clock select code
	// divider table
	function automatic logic [7:0] tad_div(input logic [2:0] s);
		logic [7:0] d;
		d = 8'(RC_DIV);
		if (s[1:0] != 2'h3)
			d = 8'h02 << (2 * s[1:0] + {1'b0, s[2]});
		return d;
	endfunction

	// One approximation step: resolve the pending bit, then try the next one
	function automatic logic [9:0] sar_step(input logic [9:0] v, input logic [3:0] idx,
		input logic hit);
		logic [9:0] r;
		r = v;
		if (idx != 4'h0 && !hit)
			r[10 - int'(idx)] = 1'b0;
		if (idx < 4'hA)
			r[9 - int'(idx)] = 1'b1;
		return r;
	endfunction

	// Result as seen through the high and low result registers
	// justified view
	function automatic logic [15:0] justified(input logic [9:0] v, input logic right);
		logic [15:0] j;
		j = {v, 6'h00};
		if (right)
			j = {6'h00, v};
		return j;
	endfunction

	wire         bus_hit  = I_HSEL && I_HTRANS[1] && I_HREADY;
	wire         in_range = (I_HADDR[11:10] == 2'h0) && (I_HADDR[1:0] == 2'h0);
	wire  [7:0]  a_idx    = I_HADDR[9:2];
	wire         rd_take  = bus_hit && !I_HWRITE;
	wire         wr_take  = bus_hit && I_HWRITE && in_range && (I_HSIZE == 3'h2);
	wire         w_c0     = wr_pend && (wr_idx == IDX_CONTROL_0);
	wire         w_c1     = wr_pend && (wr_idx == IDX_CONTROL_1);
	wire         w_flag   = wr_pend && (wr_idx == IDX_FLAG);
	wire         w_flag_en = wr_pend && (wr_idx == IDX_FLAG_EN);
	wire         w_sel_lo = wr_pend && (wr_idx == IDX_SEL_LO);
	wire         w_sel_hi = wr_pend && (wr_idx == IDX_SEL_HI);
	wire         power_nxt = w_c0 ? I_HWDATA[POS_POWER] : power;
	// go only honoured once the converter was already powered
	wire         go_set   = w_c0 && I_HWDATA[POS_GO] && power;
	wire         go_clr   = w_c0 && !I_HWDATA[POS_GO];
	wire         running  = (state == ST_CONVERT) || (state == ST_ABORT_WAIT);
	wire         tick     = running && (div_cnt == conv_div - 8'h01);
	// clearing go or power during a conversion aborts it
	wire         abort    = (state == ST_CONVERT) && (go_clr || !power_nxt);
	// eleventh bit period ends the conversion
	wire         done     = (state == ST_CONVERT) && tick && (tad_idx == CONV_TADS - 4'h1)
		&& !abort;
	wire  [9:0]  sar_nxt  = sar_step(sar, tad_idx, cmp_s2);
	wire  [15:0] res_view = justified(result, justify);
	wire  [11:0] sel      = {sel_hi, sel_lo};

	always_comb
	begin
		rd_byte = 8'h00;
		if (!in_range)
			rd_byte = 8'h00;
		else if (a_idx == IDX_CONTROL_0)
			rd_byte = {justify, ref_ext, channel, go, power};
		else if (a_idx == IDX_CONTROL_1)
			rd_byte = {1'b0, clk_sel, 4'h0};
		else if (a_idx == IDX_FLAG)
			rd_byte = 8'(done_flag) << POS_DONE;
		else if (a_idx == IDX_FLAG_EN)
			rd_byte = 8'(done_en) << POS_DONE;
		else if (a_idx == IDX_SEL_LO)
			rd_byte = sel_lo;
		else if (a_idx == IDX_SEL_HI)
			rd_byte = {4'h0, sel_hi};
		else if (a_idx == IDX_RES_HI)
			rd_byte = res_view[15:8];
		else if (a_idx == IDX_RES_LO)
			rd_byte = res_view[7:0];
	end

	always_comb
	begin
		next_state = state;
		case (state)
			ST_OFF:
				if (power)
					next_state = ST_ACQUIRE;
			// a set go flag starts the conversion
			ST_ACQUIRE:
				if (go && !go_clr)
					next_state = ST_CONVERT;
			ST_CONVERT:
				if (abort)
					next_state = ST_ABORT_WAIT;
				else if (done)
					next_state = ST_ACQUIRE;
			// two bit periods, then acquire again
			ST_ABORT_WAIT:
				if (tick && tad_idx == ABORT_TADS - 4'h1)
					next_state = ST_ACQUIRE;
			default:
				next_state = ST_OFF;
		endcase
		// power off shuts the converter down
		if (!power_nxt)
			next_state = ST_OFF;
	end

	// Bus slave: zero wait, read data captured in the address phase
	always_ff @(posedge I_MCLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			wr_pend <= 1'b0;
			wr_idx  <= 8'h00;
			hrdata  <= 32'h0000_0000;
			hready  <= 1'b1;
		end
		else
		begin
			wr_pend <= wr_take;
			wr_idx  <= a_idx;
			if (rd_take)
				hrdata <= {24'h00_0000, rd_byte};
		end
	end

	// channel, reference and format held for the analog side
	always_ff @(posedge I_MCLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			{justify, ref_ext, channel, power} <= 7'h00;
			clk_sel <= RST_CONTROL[POS_CLK_LSB +: 3];
			done_en <= 1'b0;
			sel_lo  <= RST_SEL_LO;
			sel_hi  <= RST_SEL_HI;
		end
		else
		begin
			if (w_c0)
				{justify, ref_ext, channel, power} <= {I_HWDATA[7:POS_CHAN_LSB], I_HWDATA[0]};
			if (w_c1)
				clk_sel <= I_HWDATA[POS_CLK_LSB +: 3];
			if (w_flag_en)
				done_en <= I_HWDATA[POS_DONE];
			if (w_sel_lo)
				sel_lo <= I_HWDATA[7:0];
			if (w_sel_hi)
				sel_hi <= I_HWDATA[3:0];
		end
	end

	// Hardware clear and set win over a software write in the same cycle
	// completion clears go and sets the done flag
	always_ff @(posedge I_MCLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			go        <= 1'b0;
			done_flag <= 1'b0;
			irq       <= 1'b0;
		end
		else
		begin
			if (!power_nxt || done || go_clr)
				go <= 1'b0;
			else if (go_set)
				go <= 1'b1;
			if (done)
				done_flag <= 1'b1;
			else if (w_flag)
				done_flag <= I_HWDATA[POS_DONE];
			irq <= done_flag && done_en;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			state    <= ST_OFF;
			sar      <= 10'h000;
			result   <= 10'h000;
			tad_idx  <= 4'h0;
			div_cnt  <= 8'h00;
			conv_div <= 8'h02;
			sample   <= 1'b0;
		end
		else
		begin
			state  <= next_state;
			sample <= (next_state == ST_ACQUIRE);
			if (state == ST_ACQUIRE && next_state == ST_CONVERT)
			begin
				sar      <= 10'h000;
				conv_div <= tad_div(clk_sel);
			end
			else if (state == ST_CONVERT && tick && !abort)
				sar <= sar_nxt;
			// only a finished conversion reaches the result
			if (done)
				result <= sar_nxt;
			if (next_state != state)
			begin
				tad_idx <= 4'h0;
				div_cnt <= 8'h00;
			end
			else if (tick)
			begin
				tad_idx <= tad_idx + 4'h1;
				div_cnt <= 8'h00;
			end
			else if (running)
				div_cnt <= div_cnt + 8'h01;
		end
	end

	// analog pins read zero and have their digital input off
	always_ff @(posedge I_MCLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			cmp_s1    <= 1'b0;
			cmp_s2    <= 1'b0;
			pin_s1    <= 12'h000;
			pin_s2    <= 12'h000;
			port_read <= 12'h000;
			din_en    <= 12'h000;
		end
		else
		begin
			cmp_s1    <= I_CMP_HIGH;
			cmp_s2    <= cmp_s1;
			pin_s1    <= I_PIN;
			pin_s2    <= pin_s1;
			port_read <= pin_s2 & ~sel;
			din_en    <= ~sel;
		end
	end

	// Helper counters for the timing checks
	always_ff @(posedge I_MCLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			conv_cyc  <= 16'h0000;
			abort_cyc <= 16'h0000;
		end
		else
		begin
			conv_cyc  <= (next_state == ST_CONVERT && state == ST_CONVERT) ?
				conv_cyc + 16'h0001 : 16'h0000;
			abort_cyc <= (next_state == ST_ABORT_WAIT && state == ST_ABORT_WAIT) ?
				abort_cyc + 16'h0001 : 16'h0000;
		end
	end

	assign O_HREADYOUT     = hready;
	assign O_HRDATA        = hrdata;
	assign O_HRESP         = 1'b0 & hready;
	// codes go straight to the multiplexer
	assign O_CHANNEL       = channel;
	assign O_REF_EXT       = ref_ext;
	assign O_CONV_POWER    = power;
	assign O_SAMPLE        = sample;
	assign O_DAC_CODE      = sar;
	assign O_CONV_IRQ      = irq;
	assign O_PORT_READ     = port_read;
	assign O_DIGITAL_IN_EN = din_en;

	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (!I_RESETN);

	a_conv_length: assert property (done |->
		conv_cyc == 16'(CONV_TADS) * 16'(conv_div) - 16'h0001)
		else $error("conversion did not last eleven bit periods");

	a_done_flags: assert property (done |=> (!go && done_flag))
		else $error("completion did not clear go and set done flag");

	a_irq_path: assert property ((done && done_en && !w_flag_en) |=> ##1 O_CONV_IRQ)
		else $error("enabled completion raised no interrupt");

	a_abort_keep: assert property (abort |=> ($stable(result))[*2])
		else $error("aborted conversion changed the result");

	a_abort_gap: assert property ((state == ST_ABORT_WAIT && next_state == ST_ACQUIRE)
		|-> (abort_cyc == 16'(ABORT_TADS) * 16'(conv_div) - 16'h0001) ##1 O_SAMPLE)
		else $error("abort gap not two bit periods");

	// no start in the powering write
	a_go_power: assert property ((w_c0 && !power) |=> !go)
		else $error("go set in the write that powers on");

	a_power_off: assert property (!power |-> (state == ST_OFF && !O_SAMPLE && !go))
		else $error("converter active while powered off");

	a_pin_zero: assert property (1'b1 |=> ((O_PORT_READ & $past(sel)) == 12'h000
		&& O_DIGITAL_IN_EN == ~$past(sel)))
		else $error("analog pin shows digital input");

	a_justify_hi: assert property ((rd_take && in_range && a_idx == IDX_RES_HI) |=>
		O_HRDATA[7:0] == ($past(justify) ? {6'h00, $past(result[9:8])}
		: $past(result[9:2])))
		else $error("high result register misjustified");

	// first trial sets the top bit
	a_sar_msb: assert property ((state == ST_CONVERT && tick && tad_idx == 4'h0 && !abort)
		|=> sar[9])
		else $error("first trial did not set the top bit");

endmodule

`default_nettype wire

// >>> logic/adc_ctrl_pkg.sv
// Register map, field layout and timing constants of the conversion control block
`default_nettype none
package adc_ctrl_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CONTROL_0 = 8'h1F;
	localparam logic [7:0] IDX_CONTROL_1 = 8'h9F;
	localparam logic [7:0] IDX_FLAG      = 8'h0C;
	localparam logic [7:0] IDX_FLAG_EN   = 8'h8C;
	localparam logic [7:0] IDX_SEL_LO    = 8'h91;
	localparam logic [7:0] IDX_SEL_HI    = 8'h93;
	localparam logic [7:0] IDX_RES_HI    = 8'h1E;
	localparam logic [7:0] IDX_RES_LO    = 8'h9E;

	// Field positions
	localparam int unsigned POS_JUSTIFY  = 7;
	localparam int unsigned POS_REF      = 6;
	localparam int unsigned POS_CHAN_LSB = 2;
	localparam int unsigned POS_GO       = 1;
	localparam int unsigned POS_POWER    = 0;
	localparam int unsigned POS_CLK_LSB  = 4;
	localparam int unsigned POS_DONE     = 6;

	// Reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_SEL_LO  = 8'hFF;
	localparam logic [3:0] RST_SEL_HI  = 4'hF;

	// Timing
	localparam logic [3:0]  CONV_TADS   = 4'hB;
	localparam logic [3:0]  ABORT_TADS  = 4'h2;
	localparam int unsigned CLK_NS      = 50;
	localparam int unsigned RC_TAD_NS   = 4000;
	localparam int unsigned RC_DIV_DFLT = RC_TAD_NS / CLK_NS;

	typedef enum logic [1:0] {ST_OFF, ST_ACQUIRE, ST_CONVERT, ST_ABORT_WAIT} state_t;

endpackage

`default_nettype wire

// >>> verification/adc_analog_model.sv
// Comparator model of the analog side seen by the conversion control
`timescale 1ns/100ps
`default_nettype none

module adc_analog_model
(
	input  wire logic       i_power,
	input  wire logic [9:0] i_level,
	input  wire logic [9:0] i_dac_code,
	output logic            o_cmp_high
);
	// trial compare
	// Powered-down core gives no decision, so the output rests low
	assign o_cmp_high = i_power && (i_level >= i_dac_code);
endmodule

`default_nettype wire

// >>> verification/adc_conversion_control_bench.sv
// Self-checking bench of the conversion control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end

module adc_conversion_control_bench;
	import adc_ctrl_pkg::*;
	localparam int RC = 4;
	logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, cmp, hready;
	logic [11:0] haddr = 0, pin = 12'hA5C, port_rd, din_en;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 0;
	logic [31:0] hwdata = 0, hrdata, rd, hi0, lo0;
	logic [9:0]  level = 0, dac;
	logic [3:0]  chan;
	logic        hresp, ref_ext, power, sample, irq;
	int          n_mismatch = 0, num_checks = 0, cyc = 0, n;
	always #25 clk = ~clk;

	adc_conversion_control #(.RC_DIV(RC)) dut_u (.I_MCLK(clk), .I_RESETN(rst_n), .I_HSEL(hsel),
		.I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
		.I_HWDATA(hwdata), .I_HREADY(hready), .O_HREADYOUT(hready), .O_HRDATA(hrdata),
		.O_HRESP(hresp), .I_CMP_HIGH(cmp), .O_CHANNEL(chan), .O_REF_EXT(ref_ext),
		.O_CONV_POWER(power), .O_SAMPLE(sample), .O_DAC_CODE(dac), .O_CONV_IRQ(irq),
		.I_PIN(pin), .O_PORT_READ(port_rd), .O_DIGITAL_IN_EN(din_en));
	adc_analog_model model_u (.i_power(power), .i_level(level), .i_dac_code(dac),
		.o_cmp_high(cmp));

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_mismatch++;
			finish_test();
		end
	end

	// Single word transfer; waits on the ready of each phase
	task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {2'b00, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'b010;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	function automatic int conversion_bit_period(input logic [2:0] cs);
		case (cs)
			3'b000: conversion_bit_period = 2;
			3'b100: conversion_bit_period = 4;
			3'b001: conversion_bit_period = 8;
			3'b101: conversion_bit_period = 16;
			3'b010: conversion_bit_period = 32;
			3'b110: conversion_bit_period = 64;
			default: conversion_bit_period = RC;
		endcase
	endfunction

	// Counts cycles with the sample output low, after it first drops
	task automatic low_len(output int cnt);
		n = 0;
		while (sample !== 1'b0 && n < 10)
		begin
			@(posedge clk);
			#1 n++;
		end
		cnt = 0;
		while (sample === 1'b0 && cnt < 2000)
		begin
			@(posedge clk);
			#1 cnt++;
		end
	endtask

	task automatic test_reset;
		bus(IDX_SEL_LO, 0, 0);
		`CHK(rd, 32'h000000FF)
		bus(IDX_SEL_HI, 0, 0);
		`CHK(rd, 32'h0000000F)
		bus(IDX_CONTROL_0, 0, 0);
		`CHK(rd, 32'h00000000)
		bus(8'h55, 0, 0);
		`CHK(rd, 32'h00000000)
		`CHK({din_en, port_rd, hresp}, 25'h0)
		$display("test reset done");
	endtask

	task automatic test_pins;
		bus(IDX_SEL_LO, 1, 32'h0000000F);
		bus(IDX_SEL_HI, 1, 32'h00000004);
		pin <= 12'hFFF;
		repeat (4) @(posedge clk);
		#1 `CHK(din_en, 12'hBF0)
		`CHK(port_rd, 12'hBF0)
		$display("test pins done");
	endtask

	task automatic test_convert;
		// no sleep here; RC code uses the short divider
		logic [2:0] cs[7] = '{3'b100, 3'b001, 3'b101, 3'b010, 3'b110, 3'b011, 3'b111};
		logic [9:0] lv[7] = '{10'h2B7, 10'h001, 10'h3FF, 10'h200, 10'h155, 10'h0AA, 10'h3C3};
		logic [3:0] ch;
		logic [7:0] c0;
		for (int i = 0; i < 7; i++)
		begin
			ch = (i == 6) ? 4'hB : 4'(i);
			c0 = {1'(i), 1'(i >> 1), ch, 2'b01};
			level <= lv[i];
			bus(IDX_CONTROL_1, 1, {25'h0, cs[i], 4'h0});
			bus(IDX_FLAG, 1, 0);
			bus(IDX_FLAG_EN, 1, 32'h00000040);
			bus(IDX_CONTROL_0, 1, {24'h0, c0});
			bus(IDX_CONTROL_0, 1, {24'h0, c0 | 8'h02});
			low_len(n);
			`CHK(n, 11 * conversion_bit_period(cs[i]))
			`CHK({chan, ref_ext, power}, {ch, 1'(i >> 1), 1'b1})
			`CHK(dac, lv[i])
			repeat (2) @(posedge clk);
			#1 `CHK(irq, 1'b1)
			bus(IDX_RES_HI, 0, 0);
			hi0 = rd;
			bus(IDX_RES_LO, 0, 0);
			lo0 = rd;
			if (i[0])
			begin
				`CHK({hi0, lo0}, {30'h0, lv[i][9:8], 24'h0, lv[i][7:0]})
			end
			else
			begin
				`CHK({hi0, lo0}, {24'h0, lv[i][9:2], 24'h0, lv[i][1:0], 6'h0})
			end
			bus(IDX_CONTROL_0, 0, 0);
			`CHK(rd[1], 1'b0)
			bus(IDX_FLAG, 0, 0);
			`CHK(rd, 32'h00000040)
			// next start is at least two bit periods away
			repeat (2 * conversion_bit_period(cs[i])) @(posedge clk);
		end
		$display("test convert done");
	endtask

	task automatic test_abort;
		// two-clock code: length only, the comparator sync lags a trial
		bus(IDX_FLAG_EN, 1, 0);
		bus(IDX_CONTROL_1, 1, 0);
		bus(IDX_CONTROL_0, 1, 32'h00000003);
		low_len(n);
		`CHK(n, 11 * conversion_bit_period(3'b000))
		repeat (2) @(posedge clk);
		#1 `CHK(irq, 1'b0)
		bus(IDX_RES_HI, 0, 0);
		hi0 = rd;
		bus(IDX_RES_LO, 0, 0);
		lo0 = rd;
		bus(IDX_FLAG_EN, 1, 32'h00000040);
		level <= 10'h0F0;
		bus(IDX_CONTROL_1, 1, 32'h00000010);
		bus(IDX_FLAG, 1, 0);
		bus(IDX_CONTROL_0, 1, 32'h00000003);
		repeat (20) @(posedge clk);
		bus(IDX_CONTROL_0, 1, 32'h00000001);
		#1 low_len(n);
		// two bit periods of idle before acquiring
		`CHK(n, 2 * conversion_bit_period(3'b001))
		bus(IDX_RES_HI, 0, 0);
		`CHK(rd, hi0)
		bus(IDX_RES_LO, 0, 0);
		`CHK(rd, lo0)
		bus(IDX_FLAG, 0, 0);
		`CHK(rd, 32'h0)
		`CHK(irq, 1'b0)
		$display("test abort done");
	endtask

	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		test_reset();
		test_pins();
		test_convert();
		test_abort();
		finish_test();
	end
endmodule

`default_nettype wire
